// ### mdcr_config_regs.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
module mdcr_config_regs #(
  parameter int SLEEP2_CYCLES = mdcr_pkg::SLEEP2_CYC,
  parameter int SLEEP3_CYCLES = mdcr_pkg::SLEEP3_CYC,
  parameter int GAIN_TICK_CYCLES = mdcr_pkg::GAIN_TICK_CYC
) (
  // Clock, reset, enable
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  // Register port (same clock domain)
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_wdata,
  output logic [31:0] reg_rdata,
  output logic reg_rvalid,
  // Command measurement (same clock domain)
  input wire logic [14:0] input_freq,
  input wire logic cmd_at_or_below_thr,
  // Configuration outputs
  output logic torque_per_amp_enable,
  output logic [6:0] target_id,
  output logic [1:0] serial_drive_strength,
  output logic pullup_fault_and_feedback,
  output logic [1:0] dc_supply_range,
  output logic supply_range_undefined,
  output logic [14:0] full_scale_freq,
  output logic idle_state_select,
  output logic [1:0] clock_source,
  output logic clock_source_unavailable,
  output logic outside_clock_enable,
  output logic [7:0] low_config,
  // Derived behaviour
  output logic [15:0] command_duty,
  output logic sleep_request,
  output logic gain_adjust_tick
);

  ////////////////////////////////////////////////////////////////////////////////
  // Register state
  logic [31:0] setup_first; // First configuration word
  logic [31:0] setup_second; // Second configuration word
  // Next values computed below, registered in one process
  logic [31:0] next_setup_first;
  logic [31:0] next_setup_second;
  logic [31:0] next_reg_rdata;
  logic next_reg_rvalid;

  // Writes land in the next cycle; reserved bits are masked so they read zero
  // Unmapped writes fall through and change nothing
  always_comb begin
    next_setup_first = setup_first;
    next_setup_second = setup_second;
    next_reg_rdata = reg_rdata;
    next_reg_rvalid = 1'b0;
    if (reg_wr) begin
      if (reg_addr == mdcr_pkg::ADDR_SETUP_FIRST) begin
        next_setup_first = reg_wdata & mdcr_pkg::MASK_SETUP_FIRST;
      end else if (reg_addr == mdcr_pkg::ADDR_SETUP_SECOND) begin
        next_setup_second = reg_wdata & mdcr_pkg::MASK_SETUP_SECOND;
      end
    end
    // A read and a write in one cycle return the old word
    // Reading has no side effect on the stored words
    if (reg_rd) begin
      next_reg_rvalid = 1'b1;
      // Unmapped offsets read zero
      if (reg_addr == mdcr_pkg::ADDR_SETUP_FIRST) begin
        next_reg_rdata = setup_first;
      end else if (reg_addr == mdcr_pkg::ADDR_SETUP_SECOND) begin
        next_reg_rdata = setup_second;
      end else begin
        next_reg_rdata = 32'h00000000;
      end
    end
  end

  // Register update, frozen while clk_en is low
  // Reset loads constants only, never another signal
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      setup_first <= mdcr_pkg::RESET_SETUP_FIRST;
      setup_second <= mdcr_pkg::RESET_SETUP_SECOND;
      reg_rdata <= 32'h00000000;
      reg_rvalid <= 1'b0;
    end else if (clk_en) begin
      setup_first <= next_setup_first;
      setup_second <= next_setup_second;
      reg_rdata <= next_reg_rdata;
      reg_rvalid <= next_reg_rvalid;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Field decode, straight from flip-flops
  // Fields are plain slices, so they change one cycle after the write
  // Reserved bits are masked on write and never reach an output
  assign torque_per_amp_enable = setup_first[mdcr_pkg::TPA_BIT];
  assign target_id = setup_first[mdcr_pkg::TARGET_ID_LSB +: mdcr_pkg::TARGET_ID_W];
  assign serial_drive_strength = setup_first[mdcr_pkg::DRIVE_LSB +: 2];
  assign pullup_fault_and_feedback = setup_first[mdcr_pkg::PULLUP_BIT];
  assign dc_supply_range = setup_first[mdcr_pkg::SUPPLY_LSB +: 2];
  // Flag the undefined range so the analog side can fall back safely
  assign supply_range_undefined = (dc_supply_range == mdcr_pkg::SUPPLY_UNDEFINED);
  // Full-scale frequency feeds the duty divider below
  assign full_scale_freq = setup_second[mdcr_pkg::FULL_FREQ_LSB +: mdcr_pkg::FULL_FREQ_W];
  assign idle_state_select = setup_second[mdcr_pkg::IDLE_BIT];
  assign clock_source = setup_second[mdcr_pkg::CLK_SEL_LSB +: 2];
  // Codes 1 and 2 are stored but flagged; consumers treat them as internal
  assign clock_source_unavailable = (clock_source != mdcr_pkg::CLK_SRC_INTERNAL) &&
                                    (clock_source != mdcr_pkg::CLK_SRC_EXTERNAL);
  assign outside_clock_enable = setup_second[mdcr_pkg::OUT_CLK_BIT];
  // Low byte is stored for software only; nothing here acts on it
  assign low_config = setup_second[mdcr_pkg::LOW_CFG_W-1:0];

  ////////////////////////////////////////////////////////////////////////////////
  // Duty from frequency: one registered divide, saturated at full scale
  // Trade-off: a wide divide in one cycle; the input is same-domain
  // and changes slowly, so no pipeline is worth its latency
  // Zero full scale is treated as 100% rather than left undefined
  function automatic logic [15:0] duty_of(input logic [14:0] f, input logic [14:0] fs);
    logic [30:0] num;
    logic [30:0] q;
    num = {f, 16'h0000};
    if (fs == 15'h0000) begin
      // Zero full scale: avoid divide by zero, report full duty
      q = 31'h00010000;
    end else begin
      q = num / {16'h0000, fs};
    end
    if (q > 31'h0000FFFF) begin
      duty_of = 16'hFFFF;
    end else begin
      duty_of = q[15:0];
    end
  endfunction : duty_of

  // Next duty, registered with the timers
  logic [15:0] next_command_duty;
  // Duty recomputed every cycle from the current inputs
  always_comb begin
    next_command_duty = duty_of(input_freq, full_scale_freq);
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Sleep entry and gain tick timers
  // Both counters share one width; the longest wait must fit in it
  logic [mdcr_pkg::CNT_W-1:0] low_cnt; // Cycles the command has stayed low
  logic [mdcr_pkg::CNT_W-1:0] gain_cnt; // Cycles since last gain tick
  logic [mdcr_pkg::CNT_W-1:0] next_low_cnt;
  logic [mdcr_pkg::CNT_W-1:0] next_gain_cnt;
  logic [mdcr_pkg::CNT_W-1:0] sleep_limit;
  logic next_sleep_request;
  logic next_gain_adjust_tick;

  // Sleep wait selected by bits 15:14
  // Every code is legal, so the case needs no default
  always_comb begin
    unique case (setup_second[mdcr_pkg::SLEEP_TIME_LSB +: 2])
      2'h0: sleep_limit = mdcr_pkg::CNT_W'(mdcr_pkg::SLEEP0_CYC);
      2'h1: sleep_limit = mdcr_pkg::CNT_W'(mdcr_pkg::SLEEP1_CYC);
      2'h2: sleep_limit = mdcr_pkg::CNT_W'(SLEEP2_CYCLES);
      2'h3: sleep_limit = mdcr_pkg::CNT_W'(SLEEP3_CYCLES);
    endcase
  end

  // Next counter values and the two derived outputs
  // The sleep flag holds while the command stays low; the counter parks
  always_comb begin
    next_low_cnt = low_cnt;
    next_sleep_request = 1'b0;
    // Any rise above threshold restarts the wait
    if (!cmd_at_or_below_thr) begin
      next_low_cnt = '0;
    end else if (low_cnt >= sleep_limit - 1'b1) begin
      next_sleep_request = 1'b1;
    end else begin
      next_low_cnt = low_cnt + 1'b1;
    end
    next_gain_cnt = '0;
    next_gain_adjust_tick = 1'b0;
    // Fixed gain when disabled: the counter rests at zero
    // Tick period is GAIN_TICK_CYCLES: the count runs 0 to the limit less one
    if (setup_second[mdcr_pkg::GAIN_BIT]) begin
      if (gain_cnt >= mdcr_pkg::CNT_W'(GAIN_TICK_CYCLES - 1)) begin
        next_gain_adjust_tick = 1'b1;
      end else begin
        next_gain_cnt = gain_cnt + 1'b1;
      end
    end
  end

  // Timer and duty registers, frozen while clk_en is low
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      low_cnt <= '0;
      gain_cnt <= '0;
      sleep_request <= 1'b0;
      gain_adjust_tick <= 1'b0;
      command_duty <= 16'h0000;
    end else if (clk_en) begin
      low_cnt <= next_low_cnt;
      gain_cnt <= next_gain_cnt;
      sleep_request <= next_sleep_request;
      gain_adjust_tick <= next_gain_adjust_tick;
      command_duty <= next_command_duty;
    end
  end

endmodule : mdcr_config_regs

// ### mdcr_config_regs_assertions.sv
`timescale 1ns/1ps
module mdcr_regs_chk (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_rvalid,
  // Field outputs
  input wire logic torque_per_amp_enable,
  input wire logic [6:0] target_id,
  input wire logic [1:0] dc_supply_range,
  input wire logic supply_range_undefined,
  input wire logic [14:0] full_scale_freq,
  input wire logic idle_state_select,
  input wire logic [1:0] clock_source,
  input wire logic clock_source_unavailable,
  input wire logic sleep_request,
  input wire logic gain_adjust_tick
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // Taken writes to each register
  logic wr1;
  logic wr2;
  assign wr1 = clk_en && reg_wr && reg_addr == 8'hA6;
  assign wr2 = clk_en && reg_wr && reg_addr == 8'hA8;
  a_read_answer: assert property (clk_en && reg_rd |=> reg_rvalid)
    else $error("read not answered");
  a_tpa_update: assert property (wr1 |=> torque_per_amp_enable == $past(reg_wdata[30]))
    else $error("torque enable not updated");
  a_target_update: assert property (wr1 |=> target_id == $past(reg_wdata[26:20]))
    else $error("target id not updated");
  a_supply_flag: assert property (supply_range_undefined == (dc_supply_range == 2'h3))
    else $error("supply flag wrong");
  a_freq_update: assert property (wr2 |=> full_scale_freq == $past(reg_wdata[30:16]))
    else $error("full scale not updated");
  a_idle_update: assert property (wr2 |=> idle_state_select == $past(reg_wdata[11]))
    else $error("idle select not updated");
  a_clock_flag: assert property (
    clock_source_unavailable == (clock_source == 2'h1 || clock_source == 2'h2))
    else $error("clock flag wrong");
  a_tick_single: assert property (gain_adjust_tick |=> !gain_adjust_tick)
    else $error("gain tick too long");
  // Main scenarios reached
  c_write_first: cover property (wr1);
  c_sleep_rise: cover property ($rose(sleep_request));
  c_gain_tick: cover property (gain_adjust_tick);
endmodule : mdcr_regs_chk

// ### mdcr_pkg.sv
package mdcr_pkg;
  // Register byte offsets
  localparam logic [7:0] ADDR_SETUP_FIRST = 8'hA6;
  localparam logic [7:0] ADDR_SETUP_SECOND = 8'hA8;
  // Reset values
  localparam logic [31:0] RESET_SETUP_FIRST = 32'h00000000;
  localparam logic [31:0] RESET_SETUP_SECOND = 32'h00000000;
  // Writable bit masks; reserved bits always read zero
  localparam logic [31:0] MASK_SETUP_FIRST = 32'h47F0001F;
  localparam logic [31:0] MASK_SETUP_SECOND = 32'h7FFFDFFD;
  // First register field positions
  localparam int TPA_BIT = 30;
  localparam int TARGET_ID_LSB = 20;
  localparam int TARGET_ID_W = 7;
  localparam int DRIVE_LSB = 3;
  localparam int PULLUP_BIT = 2;
  localparam int SUPPLY_LSB = 0;
  // Second register field positions
  localparam int FULL_FREQ_LSB = 16;
  localparam int FULL_FREQ_W = 15;
  localparam int SLEEP_TIME_LSB = 14;
  localparam int GAIN_BIT = 12;
  localparam int IDLE_BIT = 11;
  localparam int CLK_SEL_LSB = 9;
  localparam int OUT_CLK_BIT = 8;
  localparam int LOW_CFG_W = 8;
  // Clock rate and sleep entry / gain tick times
  localparam int CLK_MHZ = 100;
  localparam int SLEEP0_US = 50;
  localparam int SLEEP1_US = 200;
  localparam int SLEEP2_MS = 20;
  localparam int SLEEP3_MS = 200;
  localparam int GAIN_TICK_MS = 1;
  localparam int SLEEP0_CYC = SLEEP0_US * CLK_MHZ;
  localparam int SLEEP1_CYC = SLEEP1_US * CLK_MHZ;
  localparam int SLEEP2_CYC = SLEEP2_MS * 1000 * CLK_MHZ;
  localparam int SLEEP3_CYC = SLEEP3_MS * 1000 * CLK_MHZ;
  localparam int GAIN_TICK_CYC = GAIN_TICK_MS * 1000 * CLK_MHZ;
  // Counter width big enough for the longest wait
  localparam int CNT_W = 25;
  // Duty output resolution (fraction bits of full scale)
  localparam int DUTY_W = 16;
  // Clock source codes
  localparam logic [1:0] CLK_SRC_INTERNAL = 2'h0;
  localparam logic [1:0] CLK_SRC_EXTERNAL = 2'h3;
  // Supply range code that is undefined
  localparam logic [1:0] SUPPLY_UNDEFINED = 2'h3;
endpackage : mdcr_pkg

// ### tb_mdcr_config_regs.sv
`timescale 1ns/1ps
module tb_mdcr_config_regs;
  // Stimulus, all set at time zero
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic clk_en = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_wdata = 32'h00000000;
  logic [14:0] input_freq = 15'h0000;
  logic cmd_at_or_below_thr = 1'b0;
  // Observed outputs
  logic [31:0] reg_rdata;
  logic reg_rvalid, torque_per_amp_enable, pullup_fault_and_feedback, supply_range_undefined;
  logic [6:0] target_id;
  logic [1:0] serial_drive_strength, dc_supply_range, clock_source;
  logic [14:0] full_scale_freq;
  logic idle_state_select, clock_source_unavailable, outside_clock_enable;
  logic [7:0] low_config;
  logic [15:0] command_duty;
  logic sleep_request, gain_adjust_tick;
  int err_total = 0;
  int checks = 0;
  int cycles = 0;
  // Short sleep and tick counts keep the run brief
  mdcr_config_regs #(.SLEEP2_CYCLES(200), .SLEEP3_CYCLES(400), .GAIN_TICK_CYCLES(50))
    u_mdcr_config_regs (
    .clk(clk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .reg_addr(reg_addr),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid),
    .input_freq(input_freq),
    .cmd_at_or_below_thr(cmd_at_or_below_thr),
    .torque_per_amp_enable(torque_per_amp_enable),
    .target_id(target_id),
    .serial_drive_strength(serial_drive_strength),
    .pullup_fault_and_feedback(pullup_fault_and_feedback),
    .dc_supply_range(dc_supply_range),
    .supply_range_undefined(supply_range_undefined),
    .full_scale_freq(full_scale_freq),
    .idle_state_select(idle_state_select),
    .clock_source(clock_source),
    .clock_source_unavailable(clock_source_unavailable),
    .outside_clock_enable(outside_clock_enable),
    .low_config(low_config),
    .command_duty(command_duty),
    .sleep_request(sleep_request),
    .gain_adjust_tick(gain_adjust_tick)
  );
  always #5 clk = ~clk;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic end_of_test;
    $display("checks %0d err_total %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : end_of_test
  // Hang guard: the sequence needs about 26000 cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 60000) begin
      err_total++;
      end_of_test();
    end
  end
  // One-cycle strobes, driven at the falling edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(negedge clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    check(32'(reg_rvalid), 32'h00000001);
    check(reg_rdata, exp);
  endtask : rd
  task automatic t_regs;
    rd(8'hA6, 32'h00000000);
    rd(8'hA8, 32'h00000000);
    wr(8'hA6, 32'hFFFFFFFF);
    rd(8'hA6, 32'h47F0001F);
    rd(8'hA4, 32'h00000000);
    check(32'({torque_per_amp_enable, target_id}), 32'h000000FF);
    check(32'({serial_drive_strength, pullup_fault_and_feedback}), 32'h7);
    check(32'({dc_supply_range, supply_range_undefined}), 32'h7);
    wr(8'hA6, 32'h00000009);
    check(32'({serial_drive_strength, dc_supply_range, supply_range_undefined}),
      32'hA);
    // A write while clk_en is low must be ignored
    clk_en = 1'b0;
    wr(8'hA6, 32'h00000000);
    clk_en = 1'b1;
    check(32'(dc_supply_range), 32'h1);
    wr(8'hA8, 32'hFFFFFFFF);
    rd(8'hA8, 32'h7FFFDFFD);
    check(32'(low_config), 32'hFD);
    check(32'({full_scale_freq, idle_state_select, clock_source, clock_source_unavailable,
      outside_clock_enable}), 32'h000FFFFD);
    wr(8'hA8, 32'h00000200);
    check(32'({clock_source, clock_source_unavailable, outside_clock_enable}),
      32'h6);
  endtask : t_regs
  // Reset in mid-run clears both words again
  task automatic t_reset;
    wr(8'hA6, 32'h40000004);
    wr(8'hA8, 32'h00000900);
    check(32'({torque_per_amp_enable, pullup_fault_and_feedback, idle_state_select,
      outside_clock_enable}), 32'hF);
    sys_rst = 1'b1;
    repeat (2) @(negedge clk);
    sys_rst = 1'b0;
    check(32'({torque_per_amp_enable, pullup_fault_and_feedback, idle_state_select,
      outside_clock_enable}), 32'h0);
    rd(8'hA6, 32'h00000000);
    rd(8'hA8, 32'h00000000);
  endtask : t_reset
  task automatic t_duty;
    wr(8'hA8, 32'h01000000);
    input_freq = 15'h0080;
    repeat (3) @(negedge clk);
    check(32'(command_duty), 32'h00008000);
    // Above full scale the duty saturates at 100%
    input_freq = 15'h0200;
    repeat (3) @(negedge clk);
    check(32'(command_duty), 32'h0000FFFF);
  endtask : t_duty
  // Every sleep delay code; the level must not rise early
  task automatic t_sleep;
    int lim[4] = '{5000, 20000, 200, 400};
    for (int i = 0; i < 4; i++) begin
      wr(8'hA8, 32'(i) << 14);
      cmd_at_or_below_thr = 1'b1;
      repeat (lim[i] - 10) @(negedge clk);
      check(32'(sleep_request), 32'h0);
      repeat (20) @(negedge clk);
      check(32'(sleep_request), 32'h1);
      cmd_at_or_below_thr = 1'b0;
      repeat (3) @(negedge clk);
      check(32'(sleep_request), 32'h0);
    end
  endtask : t_sleep
  task automatic t_gain;
    int n;
    int k;
    int first;
    wr(8'hA8, 32'h00001000);
    n = 0;
    while (gain_adjust_tick !== 1'b1 && n < 200) begin
      @(negedge clk);
      n++;
    end
    n = 0;
    k = 0;
    first = 0;
    repeat (153) begin
      @(negedge clk);
      k++;
      if (gain_adjust_tick === 1'b1) begin
        n++;
        if (first == 0) begin
          first = k;
        end
      end
    end
    check(32'(n), 32'h3);
    // Spacing of two ticks is the tick period, 50 cycles here
    check(32'(first), 32'h32);
    wr(8'hA8, 32'h00000000);
    n = 0;
    repeat (120) begin
      @(negedge clk);
      n += int'(gain_adjust_tick === 1'b1);
    end
    check(32'(n), 32'h0);
  endtask : t_gain
  initial begin
    repeat (12) @(posedge clk);
    @(negedge clk);
    sys_rst = 1'b0;
    t_regs();
    t_reset();
    t_duty();
    t_sleep();
    t_gain();
    end_of_test();
  end
endmodule : tb_mdcr_config_regs
bind mdcr_config_regs mdcr_regs_chk u_mdcr_regs_chk (
  .clk(clk),
  .sys_rst(sys_rst),
  .clk_en(clk_en),
  .reg_addr(reg_addr),
  .reg_wr(reg_wr),
  .reg_rd(reg_rd),
  .reg_wdata(reg_wdata),
  .reg_rvalid(reg_rvalid),
  .torque_per_amp_enable(torque_per_amp_enable),
  .target_id(target_id),
  .dc_supply_range(dc_supply_range),
  .supply_range_undefined(supply_range_undefined),
  .full_scale_freq(full_scale_freq),
  .idle_state_select(idle_state_select),
  .clock_source(clock_source),
  .clock_source_unavailable(clock_source_unavailable),
  .sleep_request(sleep_request),
  .gain_adjust_tick(gain_adjust_tick)
);
